// ---- design/lsec_pkg.sv ----
// package: register map, field positions and reset values of the link status block
package lsec_pkg;
	localparam int LSEC_DW = 16;
	localparam int LSEC_AW = 5;
	localparam int LSEC_LANES = 8;
	localparam int LSEC_LSEL_W = 3;
	// register addresses
	localparam logic [4:0] LSEC_ADDR_LANE_CFG = 5'h06;
	localparam logic [4:0] LSEC_ADDR_CH_STATUS = 5'h0F;
	localparam logic [4:0] LSEC_ADDR_FAST_ERR = 5'h10;
	localparam logic [4:0] LSEC_ADDR_SLOW_ERR = 5'h11;
	localparam logic [4:0] LSEC_ADDR_SLOW_STATUS = 5'h13;
	// field positions
	localparam int LSEC_LSEL_LSB = 12;
	localparam int LSEC_LSEL_MSB = 14;
	localparam int LSEC_CH_PLL_LOCK_BIT = 0;
	localparam int LSEC_SS_PATTERN_OK_BIT = 15;
	localparam int LSEC_SS_LOS_LIVE_BIT = 14;
	localparam int LSEC_SS_BAD_CODE_BIT = 11;
	localparam int LSEC_SS_SIG_LOST_BIT = 10;
	localparam int LSEC_SS_LOS_LATCH_BIT = 9;
	localparam int LSEC_SS_SYNC_OK_BIT = 8;
	localparam int LSEC_SS_TX_EMPTY_BIT = 3;
	localparam int LSEC_SS_TX_FULL_BIT = 2;
	localparam int LSEC_SS_RX_EMPTY_BIT = 1;
	localparam int LSEC_SS_RX_FULL_BIT = 0;
	// reset, clear and saturation values
	localparam logic [15:0] LSEC_CNT_RST = 16'hFFFD;
	localparam logic [15:0] LSEC_CNT_CLR = 16'h0000;
	localparam logic [15:0] LSEC_CNT_MAX = 16'hFFFF;
	localparam logic [2:0] LSEC_LSEL_RST = 3'h0;
	// fast counter source selection
	typedef enum logic [1:0] {
		LSEC_SRC_FUNC,
		LSEC_SRC_PATTERN,
		LSEC_SRC_PRBS
	} lsec_src_t;
endpackage

// ---- design/lsec_cor_counter.sv ----
// module: 16-bit clear-on-read error counter with frozen default until first read
module lsec_cor_counter
	import lsec_pkg::*;
#(
	parameter int W = 16,
	parameter logic [W-1:0] RST_VAL = LSEC_CNT_RST
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_inc,
	input wire logic i_rd_clr,
	output logic [W-1:0] o_count
);
	logic [W-1:0] count_q;
	logic armed_q;

	// default value stays until the first read arms the counter
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			armed_q <= 1'b0;
		end else if (i_rd_clr) begin
			armed_q <= 1'b1;
		end
	end

	// read clears; an error in the read cycle is kept as a count of one
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_q <= RST_VAL;
		end else if (i_rd_clr) begin
			count_q <= {{(W-1){1'b0}}, i_inc};
		end else if (armed_q && i_inc && (count_q != {W{1'b1}})) begin
			count_q <= count_q + {{(W-1){1'b0}}, 1'b1}; // saturates at all ones
		end
	end

	assign o_count = count_q;
endmodule

// ---- design/lsec_top.sv ----
// module: channel status, lane status and clear-on-read error counters
module lsec_top
	import lsec_pkg::*;
#(
	parameter int LANES = LSEC_LANES
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_mgmt_rd,
	input wire logic i_mgmt_wr,
	input wire logic [LSEC_AW-1:0] i_mgmt_addr,
	input wire logic [LSEC_DW-1:0] i_mgmt_wdata,
	output logic [LSEC_DW-1:0] o_mgmt_rdata,
	output logic o_mgmt_rvalid,
	output logic [LSEC_LSEL_W-1:0] o_slow_lane_selector,
	input wire logic i_fast_side_pll_locked,
	input wire logic i_pseudo_random_check_pin,
	input wire logic i_fast_pattern_mode,
	input wire logic i_fast_code_err,
	input wire logic i_fast_pattern_err,
	input wire logic i_fast_prbs_err,
	input wire logic i_slow_pattern_mode,
	input wire logic [LANES-1:0] i_slow_code_err,
	input wire logic [LANES-1:0] i_slow_pattern_err,
	input wire logic [LANES-1:0] i_slow_pattern_ok,
	input wire logic [LANES-1:0] i_slow_los_pattern_live,
	input wire logic [LANES-1:0] i_slow_signal_lost,
	input wire logic [LANES-1:0] i_slow_sync_ok,
	input wire logic [LANES-1:0] i_slow_tx_fifo_empty_err,
	input wire logic [LANES-1:0] i_slow_tx_fifo_full_err,
	input wire logic [LANES-1:0] i_slow_rx_fifo_empty_err,
	input wire logic [LANES-1:0] i_slow_rx_fifo_full_err
);
	// width of the synchroniser bank: two channel levels plus four per lane
	localparam int SW = 2 + 4 * LANES;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;
	logic pll_locked_s;
	logic prbs_pin_s;
	logic [LANES-1:0] pattern_ok_s;
	logic [LANES-1:0] los_live_s;
	logic [LANES-1:0] sig_lost_s;
	logic [LANES-1:0] sync_ok_s;

	// two flops on the pll lock, prbs pin and four lane status levels; mode pins and error inputs are used unsynchronised
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {i_fast_side_pll_locked, i_pseudo_random_check_pin, i_slow_pattern_ok,
				i_slow_los_pattern_live, i_slow_signal_lost, i_slow_sync_ok};
			sync2_q <= sync1_q;
		end
	end

	// unpack the second stage; nothing reads the first stage directly
	assign {pll_locked_s, prbs_pin_s, pattern_ok_s, los_live_s, sig_lost_s, sync_ok_s} = sync2_q;

	////////////////////////////////////////////////////////////////////////////
	// management access decode

	logic [LSEC_LSEL_W-1:0] lane_sel_q;
	logic rd_ch_status;
	logic rd_fast_err;
	logic rd_slow_err;
	logic rd_slow_status;

	// one access strobe aimed at one register
	function automatic logic hit(input logic strobe, input logic [LSEC_AW-1:0] addr,
		input logic [LSEC_AW-1:0] target);
		hit = strobe && (addr == target);
	endfunction

	// read strobes per register, each carries a side effect
	assign rd_ch_status = hit(i_mgmt_rd, i_mgmt_addr, LSEC_ADDR_CH_STATUS);
	assign rd_fast_err = hit(i_mgmt_rd, i_mgmt_addr, LSEC_ADDR_FAST_ERR);
	assign rd_slow_err = hit(i_mgmt_rd, i_mgmt_addr, LSEC_ADDR_SLOW_ERR);
	assign rd_slow_status = hit(i_mgmt_rd, i_mgmt_addr, LSEC_ADDR_SLOW_STATUS);

	// lane selector field of the lane configuration register
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lane_sel_q <= LSEC_LSEL_RST;
		end else if (hit(i_mgmt_wr, i_mgmt_addr, LSEC_ADDR_LANE_CFG)) begin
			lane_sel_q <= i_mgmt_wdata[LSEC_LSEL_MSB:LSEC_LSEL_LSB];
		end
	end

	// selector leaves straight from its flop
	assign o_slow_lane_selector = lane_sel_q;

	////////////////////////////////////////////////////////////////////////////
	// latch helpers

	// latched high: hold any event until read, then take the present state
	function automatic logic latch_high(input logic q, input logic cond, input logic clr);
		latch_high = clr ? cond : (q | cond);
	endfunction

	// latched low: hold any drop until read, then take the present state
	function automatic logic latch_low(input logic q, input logic cond, input logic clr);
		latch_low = clr ? cond : (q & cond);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// channel status word

	logic pll_lock_q;

	// lost lock stays visible until software reads the word
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pll_lock_q <= 1'b0;
		end else begin
			pll_lock_q <= latch_low(pll_lock_q, pll_locked_s, rd_ch_status);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-lane latched flags

	logic [LANES-1:0] lane_clr;
	logic [LANES-1:0] bad_code_q;
	logic [LANES-1:0] sig_lost_q;
	logic [LANES-1:0] los_latch_q;
	logic [LANES-1:0] sync_ok_q;
	logic [LANES-1:0] tx_empty_q;
	logic [LANES-1:0] tx_full_q;
	logic [LANES-1:0] rx_empty_q;
	logic [LANES-1:0] rx_full_q;

	// a status read clears only the lane it shows
	always_comb begin
		lane_clr = '0;
		lane_clr[lane_sel_q] = rd_slow_status;
	end

	// every lane keeps its own flags so switching lanes loses nothing
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bad_code_q <= '0;
			sig_lost_q <= '0;
			los_latch_q <= '0;
			sync_ok_q <= '0;
			tx_empty_q <= '0;
			tx_full_q <= '0;
			rx_empty_q <= '0;
			rx_full_q <= '0;
		end else begin
			for (int i = 0; i < LANES; i++) begin
				bad_code_q[i] <= latch_high(bad_code_q[i], i_slow_code_err[i], lane_clr[i]);
				sig_lost_q[i] <= latch_high(sig_lost_q[i], sig_lost_s[i], lane_clr[i]);
				los_latch_q[i] <= latch_high(los_latch_q[i], los_live_s[i], lane_clr[i]);
				sync_ok_q[i] <= latch_low(sync_ok_q[i], sync_ok_s[i], lane_clr[i]);
				tx_empty_q[i] <= latch_high(tx_empty_q[i], i_slow_tx_fifo_empty_err[i],
					lane_clr[i]);
				tx_full_q[i] <= latch_high(tx_full_q[i], i_slow_tx_fifo_full_err[i],
					lane_clr[i]);
				rx_empty_q[i] <= latch_high(rx_empty_q[i], i_slow_rx_fifo_empty_err[i],
					lane_clr[i]);
				rx_full_q[i] <= latch_high(rx_full_q[i], i_slow_rx_fifo_full_err[i],
					lane_clr[i]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// error counters

	lsec_src_t fast_src;
	logic fast_inc;
	logic [LSEC_DW-1:0] fast_count;
	logic [LANES-1:0] slow_inc;
	logic [LANES-1:0] slow_clr;
	logic [LSEC_DW-1:0] slow_count [LANES];

	// pin-driven prbs check wins over the pattern verifier
	always_comb begin
		if (prbs_pin_s) begin
			fast_src = LSEC_SRC_PRBS;
		end else if (i_fast_pattern_mode) begin
			fast_src = LSEC_SRC_PATTERN;
		end else begin
			fast_src = LSEC_SRC_FUNC;
		end
	end

	// error source feeding the fast counter
	always_comb begin
		case (fast_src)
			LSEC_SRC_PRBS: fast_inc = i_fast_prbs_err;
			LSEC_SRC_PATTERN: fast_inc = i_fast_pattern_err;
			LSEC_SRC_FUNC: fast_inc = i_fast_code_err;
			default: fast_inc = 1'b0;
		endcase
	end

	lsec_cor_counter #(
		.W(LSEC_DW),
		.RST_VAL(LSEC_CNT_RST)
	) u_fast_cnt (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_inc(fast_inc),
		.i_rd_clr(rd_fast_err),
		.o_count(fast_count)
	);

	// per-lane sources and clear of the selected lane only
	always_comb begin
		slow_clr = '0;
		slow_clr[lane_sel_q] = rd_slow_err;
		slow_inc = i_slow_pattern_mode ? i_slow_pattern_err : i_slow_code_err;
	end

	for (genvar g = 0; g < LANES; g++) begin : g_lane_cnt
		lsec_cor_counter #(
			.W(LSEC_DW),
			.RST_VAL(LSEC_CNT_RST)
		) u_slow_cnt (
			.i_clk_sys(i_clk_sys),
			.i_rst_n(i_rst_n),
			.i_inc(slow_inc[g]),
			.i_rd_clr(slow_clr[g]),
			.o_count(slow_count[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// read data

	logic [LSEC_DW-1:0] slow_status;
	logic [LSEC_DW-1:0] rdata_d;

	// selected lane's status word, reserved bits zero
	always_comb begin
		slow_status = '0;
		slow_status[LSEC_SS_PATTERN_OK_BIT] = pattern_ok_s[lane_sel_q];
		slow_status[LSEC_SS_LOS_LIVE_BIT] = los_live_s[lane_sel_q];
		slow_status[LSEC_SS_BAD_CODE_BIT] = bad_code_q[lane_sel_q];
		slow_status[LSEC_SS_SIG_LOST_BIT] = sig_lost_q[lane_sel_q];
		slow_status[LSEC_SS_LOS_LATCH_BIT] = los_latch_q[lane_sel_q];
		slow_status[LSEC_SS_SYNC_OK_BIT] = sync_ok_q[lane_sel_q];
		slow_status[LSEC_SS_TX_EMPTY_BIT] = tx_empty_q[lane_sel_q];
		slow_status[LSEC_SS_TX_FULL_BIT] = tx_full_q[lane_sel_q];
		slow_status[LSEC_SS_RX_EMPTY_BIT] = rx_empty_q[lane_sel_q];
		slow_status[LSEC_SS_RX_FULL_BIT] = rx_full_q[lane_sel_q];
	end

	// address mux; unmapped addresses read zero
	always_comb begin
		rdata_d = '0;
		case (i_mgmt_addr)
			LSEC_ADDR_LANE_CFG: rdata_d[LSEC_LSEL_MSB:LSEC_LSEL_LSB] = lane_sel_q;
			LSEC_ADDR_CH_STATUS: rdata_d[LSEC_CH_PLL_LOCK_BIT] = pll_lock_q;
			LSEC_ADDR_FAST_ERR: rdata_d = fast_count;
			LSEC_ADDR_SLOW_ERR: rdata_d = slow_count[lane_sel_q];
			LSEC_ADDR_SLOW_STATUS: rdata_d = slow_status;
			default: rdata_d = '0;
		endcase
	end

	// answer strobe one cycle after the read strobe
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mgmt_rvalid <= 1'b0;
		end else begin
			o_mgmt_rvalid <= i_mgmt_rd;
		end
	end

	// read data keeps the value before the clear and holds until the next read
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mgmt_rdata <= '0;
		end else if (i_mgmt_rd) begin
			o_mgmt_rdata <= rdata_d;
		end
	end
endmodule

// ---- sim/lsec_top_monitor.sv ----
// checker: read port, counter and selector assertions of the status block
module lsec_top_monitor
	import lsec_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_mgmt_rd,
	input wire logic i_mgmt_wr,
	input wire logic [LSEC_AW-1:0] i_mgmt_addr,
	input wire logic [LSEC_DW-1:0] i_mgmt_wdata,
	input wire logic [LSEC_DW-1:0] o_mgmt_rdata,
	input wire logic o_mgmt_rvalid,
	input wire logic [LSEC_LSEL_W-1:0] o_slow_lane_selector,
	input wire logic i_fast_code_err,
	input wire logic i_fast_pattern_err,
	input wire logic i_fast_prbs_err
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	logic fast_seen_q;
	logic [7:0] slow_seen_q;
	logic rd_ch, rd_fe, rd_se, rd_ss, rd_un, wr_sel;
	// decoded accesses
	assign rd_ch = i_mgmt_rd && i_mgmt_addr == LSEC_ADDR_CH_STATUS;
	assign rd_fe = i_mgmt_rd && i_mgmt_addr == LSEC_ADDR_FAST_ERR;
	assign rd_se = i_mgmt_rd && i_mgmt_addr == LSEC_ADDR_SLOW_ERR;
	assign rd_ss = i_mgmt_rd && i_mgmt_addr == LSEC_ADDR_SLOW_STATUS;
	assign rd_un = i_mgmt_rd && !(rd_ch || rd_fe || rd_se || rd_ss
		|| i_mgmt_addr == LSEC_ADDR_LANE_CFG);
	assign wr_sel = i_mgmt_wr && i_mgmt_addr == LSEC_ADDR_LANE_CFG;
	// remembers which counters were read since reset
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fast_seen_q <= 1'b0;
			slow_seen_q <= 8'h00;
		end else begin
			if (rd_fe) fast_seen_q <= 1'b1;
			if (rd_se) slow_seen_q[o_slow_lane_selector] <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////
	sequence quiet_fast_read;
		rd_fe && !(i_fast_code_err || i_fast_pattern_err || i_fast_prbs_err);
	endsequence
	read_answer_a: assert property (i_mgmt_rd |=> o_mgmt_rvalid)
		else $error("read not answered");
	no_stray_a: assert property (!i_mgmt_rd |=> !o_mgmt_rvalid)
		else $error("answer without read");
	fast_default_a: assert property (rd_fe && !fast_seen_q |=> o_mgmt_rdata == LSEC_CNT_RST)
		else $error("fast counter default wrong");
	slow_default_a: assert property (rd_se && !slow_seen_q[o_slow_lane_selector]
		|=> o_mgmt_rdata == LSEC_CNT_RST)
		else $error("slow counter default wrong");
	fast_clear_a: assert property (quiet_fast_read ##1 rd_fe
		|=> o_mgmt_rdata == LSEC_CNT_CLR)
		else $error("fast counter not cleared by read");
	chan_reserved_a: assert property (rd_ch |=> o_mgmt_rdata[15:1] == 15'h0000)
		else $error("channel status reserved bits set");
	lane_reserved_a: assert property (rd_ss
		|=> o_mgmt_rdata[13:12] == 2'h0 && o_mgmt_rdata[7:4] == 4'h0)
		else $error("lane status reserved bits set");
	unmapped_zero_a: assert property (rd_un |=> o_mgmt_rdata == 16'h0000)
		else $error("unmapped read not zero");
	lane_select_a: assert property (wr_sel
		|=> o_slow_lane_selector == $past(i_mgmt_wdata[14:12]))
		else $error("lane selector not written");
	select_hold_a: assert property (!wr_sel |=> $stable(o_slow_lane_selector))
		else $error("lane selector changed");
endmodule
bind lsec_top lsec_top_monitor lsec_top_monitor_i (.i_clk_sys, .i_rst_n, .i_mgmt_rd,
	.i_mgmt_wr, .i_mgmt_addr, .i_mgmt_wdata, .o_mgmt_rdata, .o_mgmt_rvalid,
	.o_slow_lane_selector, .i_fast_code_err, .i_fast_pattern_err, .i_fast_prbs_err);

// ---- sim/tb_top.sv ----
// testbench: drives the status block and checks read data through a queue
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import lsec_pkg::*;
	logic i_clk_sys, i_rst_n, i_mgmt_rd, i_mgmt_wr, o_mgmt_rvalid;
	logic i_fast_side_pll_locked, i_pseudo_random_check_pin, i_fast_pattern_mode;
	logic i_fast_code_err, i_fast_pattern_err, i_fast_prbs_err, i_slow_pattern_mode;
	logic [4:0] i_mgmt_addr;
	logic [15:0] i_mgmt_wdata, o_mgmt_rdata;
	logic [2:0] o_slow_lane_selector, lane;
	logic [7:0] i_slow_code_err, i_slow_pattern_err, i_slow_pattern_ok, i_slow_sync_ok;
	logic [7:0] i_slow_los_pattern_live, i_slow_signal_lost, i_slow_tx_fifo_empty_err;
	logic [7:0] i_slow_tx_fifo_full_err, i_slow_rx_fifo_empty_err, i_slow_rx_fifo_full_err, v;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'hB1AAAED9;
	int fail_count, n_checks, cf, cs;
	lsec_top lsec_top_i (.i_clk_sys, .i_rst_n, .i_mgmt_rd, .i_mgmt_wr, .i_mgmt_addr,
		.i_mgmt_wdata, .o_mgmt_rdata, .o_mgmt_rvalid, .o_slow_lane_selector,
		.i_fast_side_pll_locked, .i_pseudo_random_check_pin, .i_fast_pattern_mode,
		.i_fast_code_err, .i_fast_pattern_err, .i_fast_prbs_err, .i_slow_pattern_mode,
		.i_slow_code_err, .i_slow_pattern_err, .i_slow_pattern_ok, .i_slow_los_pattern_live,
		.i_slow_signal_lost, .i_slow_sync_ok, .i_slow_tx_fifo_empty_err,
		.i_slow_tx_fifo_full_err, .i_slow_rx_fifo_empty_err, .i_slow_rx_fifo_full_err);
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task tick(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	task rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge i_clk_sys);
		i_mgmt_rd <= 1'b1;
		i_mgmt_addr <= a;
		exp_q.push_back(e);
		@(posedge i_clk_sys);
		i_mgmt_rd <= 1'b0;
	endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		i_mgmt_wr <= 1'b1;
		i_mgmt_addr <= a;
		i_mgmt_wdata <= d;
		@(posedge i_clk_sys);
		i_mgmt_wr <= 1'b0;
	endtask
	// random error pulses on every source, counting only the active one
	task burst(input int n);
		logic [2:0] f;
		logic [7:0] sc, sp;
		repeat (n) begin
			@(posedge i_clk_sys);
			f = 3'(xs());
			sc = 8'(xs());
			sp = 8'(xs());
			{i_fast_prbs_err, i_fast_pattern_err, i_fast_code_err} <= f;
			i_slow_code_err <= sc;
			i_slow_pattern_err <= sp;
			cf += i_pseudo_random_check_pin ? f[2] : i_fast_pattern_mode ? f[1] : f[0];
			cs += i_slow_pattern_mode ? sp[lane] : sc[lane];
		end
		@(posedge i_clk_sys);
		{i_fast_prbs_err, i_fast_pattern_err, i_fast_code_err} <= 3'h0;
		i_slow_code_err <= 8'h00;
		i_slow_pattern_err <= 8'h00;
	endtask
	task tally_and_finish();
		int k;
		k = 0;
		while (exp_q.size() > 0 && k < 50) begin
			@(posedge i_clk_sys);
			k++;
		end
		if (exp_q.size() > 0) begin
			fail_count++;
			$display("wrong value at %0t: reads left unanswered", $time);
		end
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// clock
	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end
	// read answer checker: oldest note against each answer
	always @(posedge i_clk_sys) begin
		if (o_mgmt_rvalid === 1'b1) begin
			n_checks++;
			if (exp_q.size() == 0) begin
				fail_count++;
				$display("wrong value at %0t: answer without read", $time);
			end else if (o_mgmt_rdata !== exp_q[0]) begin
				fail_count++;
				$display("wrong value at %0t: got %h want %h", $time, o_mgmt_rdata, exp_q[0]);
			end
			if (exp_q.size() > 0) void'(exp_q.pop_front());
		end
	end
	// main sequence
	initial begin
		{i_rst_n, i_mgmt_rd, i_mgmt_wr, i_mgmt_addr, i_mgmt_wdata} = '0;
		{i_pseudo_random_check_pin, i_fast_pattern_mode, i_slow_pattern_mode} = '0;
		{i_fast_code_err, i_fast_pattern_err, i_fast_prbs_err} = '0;
		{i_slow_code_err, i_slow_pattern_err, i_slow_los_pattern_live} = '0;
		{i_slow_signal_lost, i_slow_tx_fifo_empty_err, i_slow_tx_fifo_full_err} = '0;
		{i_slow_rx_fifo_empty_err, i_slow_rx_fifo_full_err} = '0;
		{i_fast_side_pll_locked, i_slow_pattern_ok, i_slow_sync_ok} = '1;
		tick(16);
		i_rst_n <= 1'b1;
		rd(5'h10, 16'hFFFD);
		rd(5'h0F, 16'h0000);
		rd(5'h0F, 16'h0001);
		i_fast_side_pll_locked <= 1'b0;
		tick(3);
		i_fast_side_pll_locked <= 1'b1;
		tick(4);
		rd(5'h0F, 16'h0000);
		rd(5'h0F, 16'h0001);
		rd(5'h1F, 16'h0000);
		$display("test 1 done: reset defaults and lock latch");
		lane = 3'(xs());
		v = 8'h01 << lane;
		wr(5'h06, {1'b0, lane, 12'(xs())});
		rd(5'h06, {1'b0, lane, 12'h000});
		rd(5'h11, 16'hFFFD);
		for (int m = 0; m < 3; m++) begin
			i_pseudo_random_check_pin <= (m == 2);
			i_fast_pattern_mode <= (m == 1);
			i_slow_pattern_mode <= (m == 1);
			tick(4);
			cf = 0;
			cs = 0;
			burst(20);
			@(posedge i_clk_sys);
			i_mgmt_rd <= 1'b1;
			i_mgmt_addr <= 5'h10;
			exp_q.push_back(16'(cf));
			rd(5'h10, 16'h0000);
			rd(5'h11, 16'(cs));
		end
		i_pseudo_random_check_pin <= 1'b0;
		$display("test 2 done: counters in every mode");
		rd(5'h13, 16'h8800);
		rd(5'h13, 16'h8100);
		@(posedge i_clk_sys);
		{i_slow_code_err, i_slow_signal_lost, i_slow_los_pattern_live} <= {3{v}};
		{i_slow_tx_fifo_empty_err, i_slow_tx_fifo_full_err} <= {2{v}};
		{i_slow_rx_fifo_empty_err, i_slow_rx_fifo_full_err} <= {2{v}};
		i_slow_sync_ok <= ~v;
		@(posedge i_clk_sys);
		{i_slow_code_err, i_slow_signal_lost, i_slow_los_pattern_live} <= '0;
		{i_slow_tx_fifo_empty_err, i_slow_tx_fifo_full_err} <= '0;
		{i_slow_rx_fifo_empty_err, i_slow_rx_fifo_full_err} <= '0;
		i_slow_sync_ok <= 8'hFF;
		tick(4);
		rd(5'h13, 16'h8E0F);
		rd(5'h13, 16'h8100);
		i_slow_los_pattern_live <= v;
		i_slow_pattern_ok <= ~v;
		tick(4);
		rd(5'h13, 16'h4300);
		$display("test 3 done: lane status flags");
		wr(5'h13, 16'hFFFF);
		wr(5'h10, 16'hFFFF);
		wr(5'h0F, 16'h0000);
		rd(5'h10, 16'h0000);
		rd(5'h0F, 16'h0001);
		$display("test 4 done: ignored writes");
		tally_and_finish();
	end
endmodule
